// [hdl/pvs_pkg.sv]
`default_nettype none
package pvs_pkg;
	localparam int DW = 16;
	localparam int AW = 12;
	// register indices; byte address is four times the index
	localparam logic [8:0] IDX_PROCESS_VALUE = 9'h066;
	localparam logic [8:0] IDX_CONTROL_SP    = 9'h067;
	localparam logic [8:0] IDX_ACTIVE_INDEX  = 9'h06B;
	localparam logic [8:0] IDX_AMC_SELECT    = 9'h07A;
	localparam logic [8:0] IDX_REMOTE_LOCAL  = 9'h07C;
	localparam logic [8:0] IDX_EXT_ENABLE    = 9'h07D;
	localparam logic [8:0] IDX_SP_INDEX      = 9'h080;
	localparam logic [8:0] IDX_EXT_INPUT     = 9'h083;
	localparam logic [8:0] IDX_REMOTE_SP     = 9'h085;
	localparam logic [8:0] IDX_PRESET_ONE    = 9'h0C9;
	localparam logic [8:0] IDX_PRESET_TWO    = 9'h0DD;
	localparam logic [8:0] IDX_PRESET_THREE  = 9'h0F1;
	localparam logic [8:0] IDX_PRESET_FOUR   = 9'h105;
	localparam logic [8:0] IDX_MANUAL_CHOICE = 9'h143;
	localparam logic [8:0] IDX_CO_MODE       = 9'h169;
	localparam logic [8:0] IDX_CO_UPPER      = 9'h16A;
	localparam logic [8:0] IDX_CO_LOWER      = 9'h16B;
	localparam logic [8:0] IDX_LOOP_CONFIG   = 9'h180;
	localparam logic [8:0] IDX_BACKUP_CMD    = 9'h182;
	// loop_config fields
	localparam int CFG_MODE_LSB  = 0;
	localparam int CFG_SECONDARY = 2;
	localparam int CFG_ZONE_PID  = 3;
	typedef enum logic [1:0] {
		PVS_BLEND, PVS_UPPER, PVS_MANUAL
	} pvs_co_mode_type;
	typedef enum logic [1:0] {
		PVS_SINGLE, PVS_CHANGEOVER, PVS_CASCADE
	} pvs_ctrl_mode_type;
	localparam logic [1:0] AMC_AUTO    = 2'h0;
	localparam logic [1:0] AMC_MANUAL  = 2'h1;
	localparam logic [1:0] AMC_CASCADE = 2'h2;
	localparam logic [2:0] SP_INDEX_MIN   = 3'h1;
	localparam logic [2:0] SP_INDEX_MAX   = 3'h4;
	localparam logic [2:0] SP_INDEX_RESET = 3'h1;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] CO_UPPER_RESET = 16'h0001;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMPLE_PERIOD_NS = 1000;
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [hdl/pvs_select.sv]
// Notes on behaviour
// [R01] changeover mode 0 blends by range, 1 switches at upper limit, 2 manual
// [R02] blend mode: input 1 below lower limit, input 2 above upper limit
// [R03] between limits: weighted sum, input 2 weight (in1-lower)/(upper-lower)
// [R04] lower limit not below upper: switch at upper limit only
// [R05] upper mode: input 1 while in1 <= upper limit, else input 2
// [R06] manual mode: choice 0 gives input 1, choice 1 input 2, no blending
// [R07] software gives input 1 the lower range, ranges overlapping
// [R08] external enable 1 uses the written external value as process value
// [R09] host keeps external value within -5% to 105% of input span
// [R10] burnout detection suppressed while external enable is 1
// [R11] set point comes from one of four presets, the remote value or cascade_setpoint
// [R12] single, changeover, primary loop: local selects indexed preset
// [R13] cascade secondary loop: indexed preset only while automatic
// [R14] index 1 to 4 selects preset n and its alarm preset set
// [R15] active index 1 to 4 readable in a read-only field
// [R16] zone PID disabled: index change also switches PID constant set
// [R17] amc 0 auto, 1 manual, 2 cascade; 2 only in cascade mode
// [R18] in cascade mode only the even loop of a pair governs
// [R19] presets survive power cycling only through a backup procedure
// [R20] remote select 1 takes the remote set point value
// [R21] selections re-evaluated once every sampling period
`timescale 1ns/100ps
`default_nettype none
module pvs_select #(
	parameter int  SAMPLE_CYCLES = pvs_pkg::SAMPLE_CYCLES,
	parameter bit  EVEN_LOOP     = 1'b1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] input_one,
	input  wire logic [15:0] input_two,
	input  wire logic [15:0] cascade_setpoint,
	input  wire logic [15:0] stored_setpoint_one,
	input  wire logic [15:0] stored_setpoint_two,
	input  wire logic [15:0] stored_setpoint_three,
	input  wire logic [15:0] stored_setpoint_four,
	output logic      [15:0] process_value,
	output logic      [15:0] control_setpoint,
	output logic      [2:0]  alarm_set_index,
	output logic      [2:0]  pid_set_index,
	output logic             burnout_check_enable,
	output logic             loop_in_charge,
	output logic             backup_request
);
	logic [1:0]  amc_select;
	logic        remote_local_select;
	logic        external_input_enable;
	logic [2:0]  setpoint_index_select;
	logic [15:0] external_process_input;
	logic [15:0] remote_setpoint_value;
	logic [15:0] preset [0:3];
	logic        manual_input_choice;
	logic [1:0]  changeover_mode_select;
	logic [15:0] changeover_upper_limit;
	logic [15:0] changeover_lower_limit;
	logic [1:0]  ctrl_mode;
	logic        secondary_loop;
	logic        zone_pid_enable;
	logic [2:0]  active_setpoint_index;
	logic        presets_loaded;
	logic [15:0] tick_count;
	logic        sample_tick;
	logic [15:0] next_pv;
	logic [15:0] next_csp;
	logic        setup_phase;
	logic        wr_done;
	logic        rd_take;
	logic [8:0]  idx;
	logic        mapped;
	logic [15:0] rd_val;
	logic [15:0] wd;

	assign idx = paddr[10:2];
	assign wd = pwdata[15:0];
	// one wait state: pready rises in the first access cycle's next edge
	assign setup_phase = psel && penable && !pready;
	assign wr_done = psel && penable && pready && pwrite && !pslverr;
	assign rd_take = setup_phase && !pwrite;

	always_comb begin
		mapped = 1'b1;
		rd_val = pvs_pkg::ZERO16;
		case (idx)
			pvs_pkg::IDX_PROCESS_VALUE: rd_val = process_value;
			pvs_pkg::IDX_CONTROL_SP:    rd_val = control_setpoint;
			pvs_pkg::IDX_ACTIVE_INDEX:  rd_val = {13'h0000, active_setpoint_index}; // [R15]
			pvs_pkg::IDX_AMC_SELECT:    rd_val = {14'h0000, amc_select};
			pvs_pkg::IDX_REMOTE_LOCAL:  rd_val = {15'h0000, remote_local_select};
			pvs_pkg::IDX_EXT_ENABLE:    rd_val = {15'h0000, external_input_enable};
			pvs_pkg::IDX_SP_INDEX:      rd_val = {13'h0000, setpoint_index_select};
			pvs_pkg::IDX_EXT_INPUT:     rd_val = external_process_input;
			pvs_pkg::IDX_REMOTE_SP:     rd_val = remote_setpoint_value;
			pvs_pkg::IDX_PRESET_ONE:    rd_val = preset[0];
			pvs_pkg::IDX_PRESET_TWO:    rd_val = preset[1];
			pvs_pkg::IDX_PRESET_THREE:  rd_val = preset[2];
			pvs_pkg::IDX_PRESET_FOUR:   rd_val = preset[3];
			pvs_pkg::IDX_MANUAL_CHOICE: rd_val = {15'h0000, manual_input_choice};
			pvs_pkg::IDX_CO_MODE:       rd_val = {14'h0000, changeover_mode_select};
			pvs_pkg::IDX_CO_UPPER:      rd_val = changeover_upper_limit;
			pvs_pkg::IDX_CO_LOWER:      rd_val = changeover_lower_limit;
			pvs_pkg::IDX_LOOP_CONFIG:
				rd_val = {12'h000, zone_pid_enable, secondary_loop, ctrl_mode};
			pvs_pkg::IDX_BACKUP_CMD:    rd_val = pvs_pkg::ZERO16;
			default:                    mapped = 1'b0;
		endcase
		if (paddr[1:0] != 2'h0 || paddr[11])
			mapped = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup_phase;
			pslverr <= setup_phase && !mapped;
			if (rd_take)
				prdata <= mapped ? {16'h0000, rd_val} : 32'h0000_0000;
		end
	end

	// control writes; illegal codes leave the old value in place
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amc_select <= pvs_pkg::AMC_AUTO;
			remote_local_select <= 1'b0;
			external_input_enable <= 1'b0;
			setpoint_index_select <= pvs_pkg::SP_INDEX_RESET;
			external_process_input <= pvs_pkg::ZERO16;
			remote_setpoint_value <= pvs_pkg::ZERO16;
			manual_input_choice <= 1'b0;
			changeover_mode_select <= pvs_pkg::PVS_BLEND;
			changeover_upper_limit <= pvs_pkg::CO_UPPER_RESET;
			changeover_lower_limit <= pvs_pkg::ZERO16;
			ctrl_mode <= pvs_pkg::PVS_SINGLE;
			secondary_loop <= 1'b0;
			zone_pid_enable <= 1'b0;
		end else if (wr_done) begin
			case (idx)
				pvs_pkg::IDX_AMC_SELECT:
					if (wd[1:0] == pvs_pkg::AMC_AUTO || wd[1:0] == pvs_pkg::AMC_MANUAL
							|| (wd[1:0] == pvs_pkg::AMC_CASCADE
							&& ctrl_mode == pvs_pkg::PVS_CASCADE)) // [R17]
						amc_select <= wd[1:0];
				pvs_pkg::IDX_REMOTE_LOCAL:  remote_local_select <= wd[0];
				pvs_pkg::IDX_EXT_ENABLE:    external_input_enable <= wd[0];
				pvs_pkg::IDX_SP_INDEX:
					if (wd[2:0] >= pvs_pkg::SP_INDEX_MIN && wd[2:0] <= pvs_pkg::SP_INDEX_MAX
							&& wd[15:3] == 13'h0000) // [R14]
						setpoint_index_select <= wd[2:0];
				pvs_pkg::IDX_EXT_INPUT:     external_process_input <= wd; // [R09]
				pvs_pkg::IDX_REMOTE_SP:     remote_setpoint_value <= wd;
				pvs_pkg::IDX_MANUAL_CHOICE: manual_input_choice <= wd[0];
				pvs_pkg::IDX_CO_MODE:
					if (wd[1:0] != 2'h3)
						changeover_mode_select <= wd[1:0];
				pvs_pkg::IDX_CO_UPPER:      changeover_upper_limit <= wd;
				pvs_pkg::IDX_CO_LOWER:      changeover_lower_limit <= wd;
				pvs_pkg::IDX_LOOP_CONFIG: begin
					if (wd[1:0] != 2'h3)
						ctrl_mode <= wd[1:0];
					secondary_loop <= wd[pvs_pkg::CFG_SECONDARY];
					zone_pid_enable <= wd[pvs_pkg::CFG_ZONE_PID];
				end
				default: ;
			endcase
		end else if (ctrl_mode != pvs_pkg::PVS_CASCADE && amc_select == pvs_pkg::AMC_CASCADE) begin
			// leaving cascade mode drops a cascade selection back to auto
			amc_select <= pvs_pkg::AMC_AUTO; // [R17]
		end
	end

	// presets come up from the backed-up copy, caught after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presets_loaded <= 1'b0;
			for (int i = 0; i < 4; i++)
				preset[i] <= pvs_pkg::ZERO16;
		end else if (!presets_loaded) begin
			presets_loaded <= 1'b1;
			preset[0] <= stored_setpoint_one; // [R19]
			preset[1] <= stored_setpoint_two;
			preset[2] <= stored_setpoint_three;
			preset[3] <= stored_setpoint_four;
		end else if (wr_done) begin
			case (idx)
				pvs_pkg::IDX_PRESET_ONE:   preset[0] <= wd;
				pvs_pkg::IDX_PRESET_TWO:   preset[1] <= wd;
				pvs_pkg::IDX_PRESET_THREE: preset[2] <= wd;
				pvs_pkg::IDX_PRESET_FOUR:  preset[3] <= wd;
				default: ;
			endcase
		end
	end

	// writing 1 asks the storage side to copy the presets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			backup_request <= 1'b0;
		else
			backup_request <= wr_done && idx == pvs_pkg::IDX_BACKUP_CMD && wd[0]; // [R19]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= 16'h0000;
			sample_tick <= 1'b0;
		end else if (tick_count == 16'(SAMPLE_CYCLES - 1)) begin
			tick_count <= 16'h0000;
			sample_tick <= 1'b1; // [R21]
		end else begin
			tick_count <= tick_count + 16'h0001;
			sample_tick <= 1'b0;
		end
	end

	// blend: pv = in1 + (in1-lower)*(in2-in1)/(upper-lower)
	logic signed [16:0] d_low;
	logic signed [16:0] d_in;
	logic signed [16:0] span;
	logic signed [33:0] prod;
	logic signed [33:0] quot;
	logic               above_upper;
	logic               below_lower;
	logic [15:0]        blend_pv;
	logic [15:0]        input_pv;

	assign d_low = 17'(signed'(input_one)) - 17'(signed'(changeover_lower_limit));
	assign d_in = 17'(signed'(input_two)) - 17'(signed'(input_one));
	assign span = 17'(signed'(changeover_upper_limit)) - 17'(signed'(changeover_lower_limit));
	assign prod = 34'(d_low) * 34'(d_in);
	// a span of zero or less never reaches blend_pv: the crossed-limit branch wins
	assign quot = (span > 17'sd0) ? prod / 34'(span) : 34'sd0;
	assign above_upper = signed'(input_one) > signed'(changeover_upper_limit);
	assign below_lower = signed'(input_one) < signed'(changeover_lower_limit);
	assign blend_pv = 16'(17'(signed'(input_one)) + 17'(quot[16:0])); // [R03]

	always_comb begin
		input_pv = input_one;
		case (changeover_mode_select)
			pvs_pkg::PVS_BLEND: begin // [R01]
				if (span <= 17'sd0)
					input_pv = above_upper ? input_two : input_one; // [R04]
				else if (below_lower)
					input_pv = input_one; // [R02]
				else if (above_upper)
					input_pv = input_two; // [R02]
				else
					input_pv = blend_pv; // [R03] [R07]
			end
			pvs_pkg::PVS_UPPER:
				input_pv = above_upper ? input_two : input_one; // [R05]
			pvs_pkg::PVS_MANUAL:
				input_pv = manual_input_choice ? input_two : input_one; // [R06]
			default:
				input_pv = input_one;
		endcase
		if (ctrl_mode != pvs_pkg::PVS_CHANGEOVER)
			input_pv = input_one;
		next_pv = external_input_enable ? external_process_input : input_pv; // [R08]
	end

	always_comb begin
		next_csp = preset[2'(setpoint_index_select - 3'h1)]; // [R11] [R12]
		if (ctrl_mode == pvs_pkg::PVS_CASCADE && secondary_loop) begin
			if (amc_select != pvs_pkg::AMC_AUTO)
				next_csp = cascade_setpoint; // [R13]
		end else if (remote_local_select) begin
			next_csp = remote_setpoint_value; // [R20]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			process_value <= pvs_pkg::ZERO16;
			control_setpoint <= pvs_pkg::ZERO16;
			active_setpoint_index <= pvs_pkg::SP_INDEX_RESET;
			alarm_set_index <= pvs_pkg::SP_INDEX_RESET;
			pid_set_index <= pvs_pkg::SP_INDEX_RESET;
		end else if (sample_tick && presets_loaded) begin
			process_value <= next_pv; // [R21]
			control_setpoint <= next_csp;
			active_setpoint_index <= setpoint_index_select; // [R15]
			alarm_set_index <= setpoint_index_select; // [R14]
			if (!zone_pid_enable)
				pid_set_index <= setpoint_index_select; // [R16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burnout_check_enable <= 1'b1;
			loop_in_charge <= 1'b1;
		end else begin
			burnout_check_enable <= !external_input_enable; // [R10]
			loop_in_charge <= ctrl_mode != pvs_pkg::PVS_CASCADE || EVEN_LOOP; // [R18]
		end
	end

	sequence s_apb_access;
		psel && penable && !pready;
	endsequence
	sequence s_apb_done;
		pready && psel && penable;
	endsequence

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		s_apb_access |=> s_apb_done) else $error("pready late");
	a_cascade_refused: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		(wr_done && idx == pvs_pkg::IDX_AMC_SELECT && wd[1:0] == pvs_pkg::AMC_CASCADE
		&& ctrl_mode != pvs_pkg::PVS_CASCADE) |=> amc_select != pvs_pkg::AMC_CASCADE)
		else $error("cascade accepted outside cascade mode");
	a_index_range: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
		active_setpoint_index >= pvs_pkg::SP_INDEX_MIN
		&& active_setpoint_index <= pvs_pkg::SP_INDEX_MAX)
		else $error("active index out of range");
	a_burnout_off: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		external_input_enable |=> !burnout_check_enable)
		else $error("burnout check left on");
	a_ext_pv: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
		(sample_tick && presets_loaded && external_input_enable)
		|=> process_value == $past(external_process_input))
		else $error("external value not used");
	a_upper_switch: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		(sample_tick && presets_loaded && !external_input_enable
		&& ctrl_mode == pvs_pkg::PVS_CHANGEOVER
		&& changeover_mode_select == pvs_pkg::PVS_UPPER)
		|=> process_value == ($past(above_upper) ? $past(input_two) : $past(input_one)))
		else $error("upper limit switch wrong");
	a_manual_pick: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
		(sample_tick && presets_loaded && !external_input_enable
		&& ctrl_mode == pvs_pkg::PVS_CHANGEOVER
		&& changeover_mode_select == pvs_pkg::PVS_MANUAL && manual_input_choice)
		|=> process_value == $past(input_two))
		else $error("manual choice ignored");
	a_remote_sp: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		(sample_tick && presets_loaded && remote_local_select
		&& !(ctrl_mode == pvs_pkg::PVS_CASCADE && secondary_loop))
		|=> control_setpoint == $past(remote_setpoint_value))
		else $error("remote set point not taken");
	a_tick_period: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		sample_tick |=> !sample_tick) else $error("sample tick too long");
	a_pid_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		zone_pid_enable |=> $stable(pid_set_index))
		else $error("pid set moved under zone selection");
	a_blend_low: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		(sample_tick && presets_loaded && !external_input_enable && span > 17'sd0
		&& ctrl_mode == pvs_pkg::PVS_CHANGEOVER
		&& changeover_mode_select == pvs_pkg::PVS_BLEND && below_lower)
		|=> process_value == $past(input_one))
		else $error("blend below lower limit wrong");
	a_cascade_drop: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		(ctrl_mode != pvs_pkg::PVS_CASCADE && amc_select == pvs_pkg::AMC_CASCADE && !wr_done)
		|=> amc_select == pvs_pkg::AMC_AUTO)
		else $error("cascade selection kept outside cascade mode");
	a_alarm_follow: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		(sample_tick && presets_loaded) |=> alarm_set_index == $past(setpoint_index_select))
		else $error("alarm set does not follow index");
	a_sp_index_legal: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		setpoint_index_select >= pvs_pkg::SP_INDEX_MIN
		&& setpoint_index_select <= pvs_pkg::SP_INDEX_MAX)
		else $error("set point index out of range");
endmodule
`default_nettype wire

// [tb/pvs_host.sv]
`timescale 1ns/100ps
`default_nettype none
module pvs_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h00000000;
	end
	// request held until pready is seen high; values read here are pre-edge
	task automatic xfer(input logic [8:0] idx, input logic w, input logic [15:0] d,
		output logic [15:0] q, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {1'b0, idx, 2'b00};
		pwdata  <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: only the bench watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata[15:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// callers keep ranges overlapping and external values in span
	task automatic wr(input logic [8:0] idx, input logic [15:0] d);
		logic [15:0] q;
		logic        err;
		xfer(idx, 1'b1, d, q, err);
	endtask
	task automatic rd(input logic [8:0] idx, output logic [15:0] q, output logic err);
		xfer(idx, 1'b0, 16'h0000, q, err);
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int SC = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] input_one, input_two, cascade_setpoint, process_value, control_setpoint;
	logic [2:0]  alarm_set_index, pid_set_index;
	logic        burnout_check_enable, loop_in_charge, backup_request;
	logic [15:0] q;
	logic        err;
	logic [8:0]  pidx [4];
	int          error_cnt, cmp_count, bk_cnt;

	pvs_host pvs_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	pvs_select #(.SAMPLE_CYCLES(SC), .EVEN_LOOP(1'b1)) pvs_select_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.input_one(input_one), .input_two(input_two), .cascade_setpoint(cascade_setpoint),
		.stored_setpoint_one(16'h0011), .stored_setpoint_two(16'h0022),
		.stored_setpoint_three(16'h0033), .stored_setpoint_four(16'h0044),
		.process_value(process_value), .control_setpoint(control_setpoint),
		.alarm_set_index(alarm_set_index), .pid_set_index(pid_set_index),
		.burnout_check_enable(burnout_check_enable), .loop_in_charge(loop_in_charge),
		.backup_request(backup_request));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (backup_request === 1'b1) bk_cnt++;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rchk(input string name, input logic [8:0] idx, input logic [15:0] exp);
		pvs_host_inst.rd(idx, q, err);
		chk(name, exp, q);
	endtask
	// outputs follow a register change within SC+1 cycles
	task automatic settle;
		repeat (SC + 2) @(posedge pclk);
		#1;
	endtask
	task automatic pv(input string name, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] exp);
		@(posedge pclk);
		input_one <= a;
		input_two <= b;
		settle();
		chk(name, exp, process_value);
	endtask
	task automatic final_report;
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		$display("[FAIL] watchdog expected done seen timeout");
		final_report();
	end

	initial begin
		presetn = 1'b0;
		input_one = 16'h0000;
		input_two = 16'h0000;
		cascade_setpoint = 16'h0999;
		error_cnt = 0;
		cmp_count = 0;
		bk_cnt = 0;
		pidx = '{pvs_pkg::IDX_PRESET_ONE, pvs_pkg::IDX_PRESET_TWO,
			pvs_pkg::IDX_PRESET_THREE, pvs_pkg::IDX_PRESET_FOUR};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk("amc", pvs_pkg::IDX_AMC_SELECT, 16'h0000);
		rchk("remote", pvs_pkg::IDX_REMOTE_LOCAL, 16'h0000);
		rchk("ext_en", pvs_pkg::IDX_EXT_ENABLE, 16'h0000);
		rchk("sp_index", pvs_pkg::IDX_SP_INDEX, 16'h0001);
		rchk("active", pvs_pkg::IDX_ACTIVE_INDEX, 16'h0001);
		rchk("choice", pvs_pkg::IDX_MANUAL_CHOICE, 16'h0000);
		rchk("co_mode", pvs_pkg::IDX_CO_MODE, 16'h0000);
		rchk("upper", pvs_pkg::IDX_CO_UPPER, 16'h0001);
		rchk("lower", pvs_pkg::IDX_CO_LOWER, 16'h0000);
		for (int i = 0; i < 4; i++) rchk("stored", pidx[i], 16'(16'h0011 * (i + 1)));
		pvs_host_inst.rd(9'h1FF, q, err);
		chk("unmapped err", 16'h0001, {15'h0000, err});
		chk("unmapped data", 16'h0000, q);
		$display("test reset values done");
		pvs_host_inst.wr(pvs_pkg::IDX_LOOP_CONFIG, 16'h0001);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_MODE, 16'h0001);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_UPPER, 16'h0064);
		pv("upper equal", 16'h0064, 16'h00C8, 16'h0064);
		pv("upper above", 16'h0065, 16'h00C8, 16'h00C8);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_MODE, 16'h0000);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_LOWER, 16'h0014);
		pv("blend below", 16'h000A, 16'h00C8, 16'h000A);
		pv("blend above", 16'h0078, 16'h00C8, 16'h00C8);
		pv("blend mid", 16'h003C, 16'h008C, 16'h0064);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_LOWER, 16'h00C8);
		pv("limits crossed lo", 16'h0064, 16'h00C8, 16'h0064);
		pv("limits crossed hi", 16'h0065, 16'h00C8, 16'h00C8);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_MODE, 16'h0002);
		pv("manual one", 16'h0065, 16'h00C8, 16'h0065);
		pvs_host_inst.wr(pvs_pkg::IDX_MANUAL_CHOICE, 16'h0001);
		pv("manual two", 16'h0010, 16'h00C8, 16'h00C8);
		pvs_host_inst.wr(pvs_pkg::IDX_CO_MODE, 16'h0003);
		rchk("co_mode bad", pvs_pkg::IDX_CO_MODE, 16'h0002);
		pvs_host_inst.wr(pvs_pkg::IDX_EXT_INPUT, 16'h0123);
		pvs_host_inst.wr(pvs_pkg::IDX_EXT_ENABLE, 16'h0001);
		settle();
		chk("ext pv", 16'h0123, process_value);
		rchk("pv reg", pvs_pkg::IDX_PROCESS_VALUE, 16'h0123);
		chk("burnout off", 16'h0000, {15'h0000, burnout_check_enable});
		pvs_host_inst.wr(pvs_pkg::IDX_EXT_ENABLE, 16'h0000);
		settle();
		chk("burnout on", 16'h0001, {15'h0000, burnout_check_enable});
		chk("normal pv", 16'h00C8, process_value);
		$display("test process value done");
		for (int i = 0; i < 4; i++) pvs_host_inst.wr(pidx[i], 16'(16'h0101 * (i + 1)));
		for (int i = 0; i < 4; i++) begin
			pvs_host_inst.wr(pvs_pkg::IDX_SP_INDEX, 16'(i + 1));
			settle();
			chk("csp", 16'(16'h0101 * (i + 1)), control_setpoint);
			rchk("csp reg", pvs_pkg::IDX_CONTROL_SP, 16'(16'h0101 * (i + 1)));
			rchk("active", pvs_pkg::IDX_ACTIVE_INDEX, 16'(i + 1));
			chk("alarm set", 16'(i + 1), {13'h0000, alarm_set_index});
			chk("pid set", 16'(i + 1), {13'h0000, pid_set_index});
		end
		pvs_host_inst.wr(pvs_pkg::IDX_SP_INDEX, 16'h0005);
		rchk("index bad", pvs_pkg::IDX_SP_INDEX, 16'h0004);
		pvs_host_inst.wr(pvs_pkg::IDX_LOOP_CONFIG, 16'h0009);
		pvs_host_inst.wr(pvs_pkg::IDX_SP_INDEX, 16'h0001);
		settle();
		chk("pid zoned", 16'h0004, {13'h0000, pid_set_index});
		chk("alarm zoned", 16'h0001, {13'h0000, alarm_set_index});
		pvs_host_inst.wr(pvs_pkg::IDX_ACTIVE_INDEX, 16'h0003);
		rchk("active ro", pvs_pkg::IDX_ACTIVE_INDEX, 16'h0001);
		pvs_host_inst.wr(pvs_pkg::IDX_CONTROL_SP, 16'h7777);
		rchk("csp ro", pvs_pkg::IDX_CONTROL_SP, 16'h0101);
		pvs_host_inst.wr(pvs_pkg::IDX_REMOTE_SP, 16'h0555);
		pvs_host_inst.wr(pvs_pkg::IDX_REMOTE_LOCAL, 16'h0001);
		settle();
		chk("remote csp", 16'h0555, control_setpoint);
		pvs_host_inst.wr(pvs_pkg::IDX_REMOTE_LOCAL, 16'h0000);
		$display("test set point done");
		pvs_host_inst.wr(pvs_pkg::IDX_AMC_SELECT, 16'h0002);
		rchk("amc early", pvs_pkg::IDX_AMC_SELECT, 16'h0000);
		pvs_host_inst.wr(pvs_pkg::IDX_LOOP_CONFIG, 16'h0006);
		pvs_host_inst.wr(pvs_pkg::IDX_AMC_SELECT, 16'h0002);
		rchk("amc cascade", pvs_pkg::IDX_AMC_SELECT, 16'h0002);
		@(posedge pclk);
		cascade_setpoint <= 16'h0ABC;
		settle();
		chk("secondary csp", 16'h0ABC, control_setpoint);
		chk("even loop", 16'h0001, {15'h0000, loop_in_charge});
		pvs_host_inst.wr(pvs_pkg::IDX_AMC_SELECT, 16'h0000);
		settle();
		chk("secondary auto", 16'h0101, control_setpoint);
		pv("cascade pv", 16'h0065, 16'h00C8, 16'h0065);
		pvs_host_inst.wr(pvs_pkg::IDX_AMC_SELECT, 16'h0002);
		pvs_host_inst.wr(pvs_pkg::IDX_LOOP_CONFIG, 16'h0001);
		rchk("amc dropped", pvs_pkg::IDX_AMC_SELECT, 16'h0000);
		pvs_host_inst.wr(pvs_pkg::IDX_BACKUP_CMD, 16'h0001);
		repeat (3) @(posedge pclk);
		chk("backup pulses", 16'h0001, 16'(bk_cnt));
		$display("test cascade and backup done");
		final_report();
	end
endmodule
`default_nettype wire
